// >>> output_setup_map.vh
// Register offsets, function codes and reset values for the output setup block
`ifndef OUTPUT_SETUP_MAP_VH
`define OUTPUT_SETUP_MAP_VH
`define OVERCURRENT_STATUS_ADDR 16'h004e
`define OVERCURRENT_STATUS_RESET 16'h0000
`define FUNC_USER 5'h10
`define FUNC_MOTION 5'h11
`define FUNC_ERROR 5'h12
`define FUNC_VELOCITY 5'h14
`define FUNC_STALL 5'h15
`define FUNC_POSITION 5'h17
`define FUNC_COMPENSATE 5'h18
`define FUNC_MAKEUP 5'h19
`define FUNC_TRIP 5'h1c
`define FUNC_ATTENTION 5'h1d
`define FUNC_RESET 5'h10
`define POLARITY_RESET 1'b0
`define ERR_NONE 8'h00
`define ERR_OUT1_FAULT 8'h01
`define ERR_OUT2_FAULT 8'h02
`define ERR_BAD_LINE 8'h0a
`define ERR_BAD_FUNC 8'h15
`endif

// >>> output_setup.v
// Output function setup, polarity and over-current fault status for three output lines
`timescale 1ns/1ps
`include "output_setup_map.vh"

// Contract
// - Fault status code: 0 none, 1 output one, 2 output two, 3 both.
// - Fault status is read-only, covers outputs one and two, resets to zero.
// - New over-current fault also posts error code one or two; latest error only.
// - Each line holds function type and polarity; defaults type 16, active low.
// - Config read without line selector returns every line in turn.
// - Type 16 follows values from set-output and set-all-outputs commands.
// - Type 17 active during motion, hold-current delay or settling delay.
// - Type 18 active while error exists; cleared by error read or zero write.
// - Type 20 mirrors the velocity-changing flag.
// - Type 21 shows stalled rotor; only on compensation-capable variants.
// - Type 23 follows the position move flag alone, without hold or settle delays.
// - Type 24 shows load compensation active; type 25 make-up steps active.
// - Type 28 shows trip event, line three only, always active low.
// - Type 29 follows the attention mask condition.
// - Single-output variant rejects lines one and two with error code 10.
module output_setup #(
   parameter HAS_COMPENSATION = 1, // Variant has load-compensation hardware
   parameter ONLY_LINE3 = 0 // Variant has output line three only
) (
   input wire mclk, // 100 MHz clock
   input wire rst, // Synchronous reset, active high
   input wire cfg_wr, // Write pulse for output_function_config
   input wire [1:0] cfg_line, // Line selector 1..3
   input wire [4:0] cfg_func, // Function type code
   input wire cfg_pol, // 1 active high, 0 active low
   input wire cfg_rd_all, // Pulse: read all line settings in turn
   output reg cfg_rd_valid, // One-cycle pulse per line returned
   output reg [1:0] cfg_rd_line, // Line number of returned setting
   output reg [4:0] cfg_rd_func, // Returned function type
   output reg cfg_rd_pol, // Returned polarity
   input wire [2:0] set_out_wr, // Per-line set-output strobes
   input wire [2:0] set_out_val, // Per-line set-output values
   input wire set_all_outputs_wr, // set_all_outputs strobe
   input wire [2:0] set_all_outputs_val, // Bit 0 is line one
   input wire axis_motion_flag, // Axis moving
   input wire hold_current_delay, // Hold-current delay running
   input wire settling_delay, // Settling delay running
   input wire velocity_changing_flag, // Accel or decel in progress
   input wire stalled_rotor_flag, // Locked rotor detected
   input wire position_move_flag, // Absolute or relative move in progress
   input wire load_compensation_mode, // Compensation working
   input wire step_makeup_mode, // Make-up steps correcting
   input wire trip_event, // Assigned trip occurred
   input wire attention_mask, // Masked attention condition active
   input wire [1:0] overcurrent_det, // Over-current detectors, outputs 1 and 2
   input wire err_wr, // last_error_code write strobe
   input wire [7:0] err_wr_data, // last_error_code write data
   input wire err_rd, // last_error_code read strobe
   input wire rd_en, // Status register read strobe
   input wire [15:0] rd_addr, // Status register address
   output reg [15:0] rd_data, // Status register read data
   output reg [7:0] last_error_code, // Most recent error posted
   output reg [2:0] out_pin // Output line levels, bit 0 is line one
);
   reg [14:0] func_q; // Three 5-bit function codes
   reg [2:0] pol_q;
   reg [2:0] user_q;
   reg [1:0] overcurrent_status_q;
   reg err_active_q;
   reg [1:0] rd_cnt_q;
   reg func_ok;
   reg [7:0] err_d;
   wire [1:0] fault_rise;
   wire [2:0] user_d; // Next user level per line
   wire [2:0] pin_d; // Next pin level per line
   wire bad_line; // Write names a line this variant lacks
   wire err_post; // Some error is posted this cycle
   genvar g;

   assign fault_rise = overcurrent_det & ~overcurrent_status_q;

   // Refusals and faults; a repeated code must still raise the error indication
   assign bad_line = cfg_wr && (cfg_line == 2'd0 || (ONLY_LINE3 != 0 && cfg_line != 2'd3));
   assign err_post = (|fault_rise) || bad_line || (cfg_wr && !func_ok) ||
                     (err_wr && err_wr_data != `ERR_NONE);

   // Type legality check; variant options gate the compensation codes
   always @* begin
      case (cfg_func)
         `FUNC_USER, `FUNC_MOTION, `FUNC_ERROR, `FUNC_VELOCITY, `FUNC_POSITION,
         `FUNC_ATTENTION: func_ok = 1'b1;
         `FUNC_STALL, `FUNC_COMPENSATE, `FUNC_MAKEUP: func_ok = (HAS_COMPENSATION != 0);
         `FUNC_TRIP: func_ok = (cfg_line == 2'd3);
         default: func_ok = 1'b0;
      endcase
   end

   // Configuration store; rejected writes leave the line untouched
   always @(posedge mclk) begin
      if (rst) begin
         func_q <= {3{`FUNC_RESET}};
         pol_q <= {3{`POLARITY_RESET}};
      end else if (cfg_wr && cfg_line != 2'd0 && func_ok &&
                   !(ONLY_LINE3 != 0 && cfg_line != 2'd3)) begin
         func_q[(cfg_line - 2'd1) * 5 +: 5] <= cfg_func;
         pol_q[cfg_line - 2'd1] <= cfg_pol;
      end
   end

   // User-driven levels; per-line strobes win over the total write
   always @(posedge mclk) begin
      if (rst) begin
         user_q <= 3'h0;
      end else begin
         user_q <= user_d;
      end
   end

   // Error code posting; a new fault this cycle beats a software clear
   always @* begin
      err_d = last_error_code;
      if (err_wr) begin
         err_d = err_wr_data;
      end
      if (bad_line) begin
         err_d = `ERR_BAD_LINE;
      end else if (cfg_wr && !func_ok) begin
         err_d = `ERR_BAD_FUNC;
      end
      if (fault_rise[0]) begin
         err_d = `ERR_OUT1_FAULT;
      end
      if (fault_rise[1]) begin
         err_d = `ERR_OUT2_FAULT;
      end
   end

   // Error register, error indication and fault status
   always @(posedge mclk) begin
      if (rst) begin
         last_error_code <= `ERR_NONE;
         err_active_q <= 1'b0;
         overcurrent_status_q <= 2'b00;
      end else begin
         last_error_code <= err_d;
         overcurrent_status_q <= overcurrent_det;
         if (err_post) begin
            err_active_q <= 1'b1;
         end else if (err_rd || (err_wr && err_wr_data == `ERR_NONE)) begin
            err_active_q <= 1'b0;
         end
      end
   end

   // Read-only status port; unmapped addresses read zero
   always @(posedge mclk) begin
      if (rst) begin
         rd_data <= `OVERCURRENT_STATUS_RESET;
      end else if (rd_en && rd_addr == `OVERCURRENT_STATUS_ADDR) begin
         rd_data <= {14'h0, overcurrent_status_q};
      end else begin
         rd_data <= 16'h0000;
      end
   end

   // Read-all walker: lines one to three, one per cycle
   always @(posedge mclk) begin
      if (rst) begin
         rd_cnt_q <= 2'd0;
         cfg_rd_valid <= 1'b0;
         cfg_rd_line <= 2'd0;
         cfg_rd_func <= 5'h00;
         cfg_rd_pol <= 1'b0;
      end else begin
         cfg_rd_valid <= 1'b0;
         if (rd_cnt_q != 2'd0) begin
            cfg_rd_valid <= 1'b1;
            cfg_rd_line <= rd_cnt_q;
            cfg_rd_func <= func_q[(rd_cnt_q - 2'd1) * 5 +: 5];
            cfg_rd_pol <= pol_q[rd_cnt_q - 2'd1];
            rd_cnt_q <= (rd_cnt_q == 2'd3) ? 2'd0 : rd_cnt_q + 2'd1;
         end else if (cfg_rd_all) begin
            rd_cnt_q <= 2'd1;
         end
      end
   end

   // Per-line user level, source select and pin level, one copy per line
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_line
         wire [4:0] line_func; // This line's function type
         reg src_act; // Selected source, active high
         assign line_func = func_q[g * 5 +: 5];
         // Per-line strobe beats the total write for its own bit
         assign user_d[g] = set_out_wr[g] ? set_out_val[g] :
                            (set_all_outputs_wr ? set_all_outputs_val[g] : user_q[g]);

         // Source mux; unknown codes cannot be stored, default is a guard
         always @* begin
            case (line_func)
               `FUNC_USER: src_act = user_q[g];
               `FUNC_MOTION: src_act = axis_motion_flag | hold_current_delay |
                                       settling_delay;
               `FUNC_ERROR: src_act = err_active_q;
               `FUNC_VELOCITY: src_act = velocity_changing_flag;
               `FUNC_STALL: src_act = stalled_rotor_flag;
               `FUNC_POSITION: src_act = position_move_flag;
               `FUNC_COMPENSATE: src_act = load_compensation_mode;
               `FUNC_MAKEUP: src_act = step_makeup_mode;
               `FUNC_TRIP: src_act = trip_event;
               `FUNC_ATTENTION: src_act = attention_mask;
               default: src_act = 1'b0;
            endcase
         end

         // Trip ignores the polarity bit: it is only ever active low
         assign pin_d[g] = (line_func == `FUNC_TRIP) ? ~src_act :
                           (pol_q[g] ? src_act : ~src_act);
      end
   endgenerate

   // Pin levels registered so the loads never see a decode glitch
   always @(posedge mclk) begin
      if (rst) begin
         out_pin <= 3'b111; // Inactive for active-low default
      end else begin
         out_pin <= pin_d;
      end
   end
endmodule // output_setup

// >>> output_setup_asserts.sv
// Assertion checker for the output setup block
`timescale 1ns/1ps
module output_setup_asserts (
   input wire mclk, // Clock
   input wire rst, // Sync reset
   input wire cfg_wr, // Config write
   input wire [1:0] cfg_line, // Config line
   input wire [4:0] cfg_func, // Config type
   input wire cfg_rd_valid, // Read-all strobe
   input wire [1:0] cfg_rd_line, // Read-all line
   input wire [1:0] overcurrent_det, // Detectors
   input wire err_wr, // Error write
   input wire rd_en, // Status read
   input wire [15:0] rd_addr, // Status address
   input wire [15:0] rd_data, // Status data
   input wire [7:0] last_error_code // Latest error
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Status mirrors detectors one cycle late, read one cycle later
   a_status_code: assert property (rd_en && rd_addr == 16'h004e |=>
      rd_data == {14'h0, $past(overcurrent_det, 2)}) else $error("status code wrong");
   a_status_quiet: assert property (!(rd_en && rd_addr == 16'h004e) |=>
      rd_data == 16'h0000) else $error("status data not zero");
   // A new fault posts its code; output two wins a tie
   a_fault_one: assert property ($rose(overcurrent_det[0]) && !$rose(overcurrent_det[1])
      |=> last_error_code == 8'h01) else $error("fault one code wrong");
   a_fault_two: assert property ($rose(overcurrent_det[1]) |=>
      last_error_code == 8'h02) else $error("fault two code wrong");
   a_bad_line: assert property (cfg_wr && cfg_line == 2'd0 && !$rose(overcurrent_det[0])
      && !$rose(overcurrent_det[1]) |=>
      last_error_code == 8'h0a) else $error("bad line not refused");
   a_trip_line: assert property (cfg_wr && cfg_line != 2'd3 && cfg_line != 2'd0
      && cfg_func == 5'h1c && !$rose(overcurrent_det[0]) && !$rose(overcurrent_det[1])
      |=> last_error_code == 8'h15) else $error("trip line");
   a_read_walk: assert property (cfg_rd_valid && cfg_rd_line == 2'd1 |=> cfg_rd_valid
      && cfg_rd_line == 2'd2 ##1 cfg_rd_valid && cfg_rd_line == 2'd3 ##1 !cfg_rd_valid)
      else $error("read-all walk wrong");
   // Error code only moves for a cause
   a_err_hold: assert property (!cfg_wr && !err_wr && !$rose(overcurrent_det[0])
      && !$rose(overcurrent_det[1]) |=>
      $stable(last_error_code)) else $error("error code moved");
   c_walk: cover property (cfg_rd_valid && cfg_rd_line == 2'd3);
   c_both: cover property (overcurrent_det == 2'b11);
   c_refuse: cover property (cfg_wr && cfg_line == 2'd0);
endmodule // output_setup_asserts
bind output_setup output_setup_asserts chk (.*);

// >>> load_model.sv
// Load model: over-current detectors on power outputs one and two
`timescale 1ns/1ps
module load_model (
   input wire [2:0] out_pin, // Output levels
   input wire [1:0] short_cmd, // Shorted load on outputs 1, 2
   output wire [1:0] overcurrent_det // Detector levels
);
   // Current only flows while a sinking output pulls low
   assign overcurrent_det = short_cmd & ~out_pin[1:0];
endmodule // load_model

// >>> testbench.sv
// Self-checking testbench for the output setup block
`timescale 1ns/1ps
module testbench;
   logic mclk = 0, rst = 1, cfg_wr = 0, cfg_pol = 0, cfg_rd_all = 0, trip_event = 0;
   logic set_all_outputs_wr = 0, err_wr = 0, err_rd = 0, rd_en = 0, cfg_rd_valid, cfg_rd_pol;
   logic [1:0] cfg_line = 0, short_cmd = 0, overcurrent_det, cfg_rd_line;
   logic [4:0] cfg_func = 0, cfg_rd_func;
   logic [2:0] set_out_wr = 0, set_out_val = 0, set_all_outputs_val = 0, out_pin;
   logic [7:0] err_wr_data = 0, last_error_code;
   logic [15:0] rd_addr = 0, rd_data;
   logic [8:0] src = 0;
   logic [4:0] ft [9] = '{5'h11, 5'h11, 5'h11, 5'h14, 5'h15, 5'h17, 5'h18, 5'h19, 5'h1d};
   wire axis_motion_flag, hold_current_delay, settling_delay, velocity_changing_flag;
   wire stalled_rotor_flag, position_move_flag, load_compensation_mode, step_makeup_mode;
   wire attention_mask;
   int n_errors = 0, n_compared = 0;
   // One source bit per entry of the type table
   assign {attention_mask, step_makeup_mode, load_compensation_mode, position_move_flag,
      stalled_rotor_flag, velocity_changing_flag, settling_delay, hold_current_delay,
      axis_motion_flag} = src;
   output_setup dut (.*);
   load_model loads (.out_pin, .short_cmd, .overcurrent_det);
   task automatic chk(input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cfg(input logic [1:0] l, input logic [4:0] f, input logic p);
      @(negedge mclk);
      {cfg_wr, cfg_line, cfg_func, cfg_pol} = {1'b1, l, f, p};
      @(negedge mclk);
      cfg_wr = 0;
      @(negedge mclk);
   endtask
   task automatic stat(input logic [15:0] exp);
      @(negedge mclk);
      rd_en = 1;
      @(negedge mclk);
      rd_en = 0;
      chk(rd_data, exp);
   endtask
   task automatic rdall(input logic [4:0] f1, input logic p1);
      int k = 0;
      cfg_rd_all = 1;
      @(negedge mclk);
      cfg_rd_all = 0;
      repeat (6) begin
         @(negedge mclk);
         if (cfg_rd_valid === 1'b1) begin
            k++;
            chk({cfg_rd_line, cfg_rd_func, cfg_rd_pol}, k == 1 ? {2'd1, f1, p1} : {k[1:0], 6'h20});
         end
      end
      chk(k, 3);
   endtask
   task automatic t_user;
      {set_all_outputs_wr, set_all_outputs_val} = 4'b1101;
      repeat (3) @(negedge mclk);
      chk(out_pin, 3'b010);
      {set_out_wr, set_out_val, set_all_outputs_val} = 9'o220;
      @(negedge mclk);
      {set_out_wr, set_all_outputs_wr} = 0;
      repeat (3) @(negedge mclk);
      chk(out_pin, 3'b101);
   endtask
   task automatic t_funcs;
      for (int i = 0; i < 9; i++) begin
         cfg(2'd1, ft[i], 1);
         src = 9'h1 << i;
         repeat (2) @(negedge mclk);
         chk(out_pin[0], 1);
         src = 0;
         repeat (2) @(negedge mclk);
         chk(out_pin[0], 0);
      end
   endtask
   task automatic t_fault;
      for (int i = 1; i < 4; i += 2) begin
         short_cmd = i[1:0];
         repeat (3) @(negedge mclk);
         stat(i);
         chk(last_error_code, (i + 1) / 2);
      end
      short_cmd = 0;
      repeat (3) @(negedge mclk);
      stat(0); // Fault bits drop with the detectors
   endtask
   task automatic t_refuse;
      cfg(2'd1, 5'h13, 0);
      chk(last_error_code, 8'h15);
      cfg(2'd0, 5'h10, 0);
      chk(last_error_code, 8'h0a);
      cfg(2'd2, 5'h1c, 0);
      chk(last_error_code, 8'h15);
      rdall(5'h1d, 1); // Refused writes leave line one as it was
      cfg(2'd3, 5'h1c, 1);
      chk(out_pin[2], 1);
      trip_event = 1;
      repeat (2) @(negedge mclk);
      chk(out_pin[2], 0);
   endtask
   // Error type: a repeated code must raise the indication again
   task automatic t_error;
      cfg(2'd2, 5'h12, 1);
      for (int n = 0; n < 2; n++) begin
         err_rd = 1;
         @(negedge mclk);
         err_rd = 0;
         repeat (2) @(negedge mclk);
         chk(out_pin[1], 0);
         cfg(2'd0, 5'h10, 0);
         chk(out_pin[1], 1);
      end
      {err_wr, err_wr_data} = 9'h100;
      @(negedge mclk);
      err_wr = 0;
      repeat (2) @(negedge mclk);
      chk(out_pin[1], 0);
      chk(last_error_code, 0);
   endtask
   // Free-running 100 MHz clock
   initial forever #5 mclk = ~mclk;
   // Hang guard, far beyond the roughly 150 cycles needed
   initial begin
      #100us;
      n_errors++;
      print_verdict;
   end
   initial begin
      repeat (16) @(negedge mclk);
      rst = 0;
      chk(out_pin, 3'b111);
      chk(last_error_code, 0);
      stat(0);
      rd_addr = 16'h004e;
      stat(0);
      rdall(5'h10, 0);
      t_user;
      t_funcs;
      t_fault;
      t_refuse;
      t_error;
      print_verdict;
   end
endmodule // testbench
